//--- src/ptpcc_top.sv
// ptpcc_top: timing command and control register bank with axi4-lite slave
`default_nettype none
module ptpcc_top
    import ptpcc_pkg::*;
(
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // configuration strap (pin)
    input wire logic enable_strap,
    // axi4-lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // clock datapath side (same clock)
    input wire ptpcc_time_s clock_now,
    input wire logic frame_busy,
    output ptpcc_cmd_s cmd,
    output logic unit_enable,
    output logic frame_start_allow,
    output logic [7:0] rise_cap_flag,
    output logic [7:0] fall_cap_flag
);
    // strap synchroniser; stage one feeds stage two only
    logic strap_s1;
    logic strap_s2;
    logic strap_pending;
    always_ff @(posedge aclk) begin
        if (clk_en) begin
            strap_s1 <= enable_strap;
            strap_s2 <= strap_s1;
        end
    end

    // frame_busy from same clock, no synchroniser needed
    logic [3:0] cap_sel;
    logic disable_pending;
    logic [7:0] rise_clr;
    logic [7:0] fall_clr;
    ptpcc_time_s rise_cap [NUM_GPIO];
    ptpcc_time_s fall_cap [NUM_GPIO];

    // write channel: address and data taken in either order
    logic aw_held;
    logic w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (clk_en) begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
        end
    end

    // write response one cycle after both halves are held
    logic wr_hit;
    assign wr_hit = aw_addr == ADDR_CMD_CTL || aw_addr == ADDR_CAP_SEL
        || aw_addr == ADDR_GPIO_CAP_CONFIG || aw_addr == ADDR_FRAME_CTL;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (clk_en) begin
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // command strobe: a write to the command word with byte lanes present
    logic cmd_wr;
    logic lo_lane;
    logic hi_lane;
    assign cmd_wr = wr_fire && aw_addr == ADDR_CMD_CTL;
    assign lo_lane = cmd_wr && w_strb[0];
    assign hi_lane = cmd_wr && w_strb[1];

    // pulses: only a written one fires, each lasts one cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd <= '0;
        end else if (clk_en) begin
            cmd.target_snap <= hi_lane && w_data[BIT_TARGET_READ];
            cmd.man_capture <= hi_lane && w_data[BIT_MAN_CAP];
            cmd.temp_rate <= lo_lane && w_data[BIT_TEMP_RATE];
            cmd.step_ns <= lo_lane && w_data[BIT_STEP_NS];
            cmd.step_sec <= lo_lane && w_data[BIT_STEP_SEC];
            cmd.load <= lo_lane && w_data[BIT_LOAD];
            cmd.snap <= lo_lane && w_data[BIT_READ];
            cmd.unit_reset <= lo_lane && w_data[BIT_RESET];
        end
    end

    // bvalid blocks the next write, so no pulse can run two cycles
    property p_cmd_once;
        @(posedge aclk) disable iff (!aresetn)
        clk_en && cmd != '0 |=> cmd == '0;
    endproperty
    a_cmd_once: assert property (p_cmd_once)
        else $error("command pulse lasted two cycles");

    // capture select field, reset clears it alongside unit reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cap_sel <= SEL_RESET;
        end else if (clk_en) begin
            if (lo_lane && w_data[BIT_RESET]) begin
                cap_sel <= SEL_RESET;
            end else if (cmd_wr && w_strb[1]) begin
                cap_sel <= w_data[SEL_MSB:SEL_LSB];
            end else if (wr_fire && aw_addr == ADDR_CAP_SEL
                && w_strb[0]) begin
                cap_sel <= w_data[3:0];
            end
        end
    end

    // enable: strap value taken once after reset release (strap_pending)
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            unit_enable <= 1'b0;
            strap_pending <= 1'b1;
            disable_pending <= 1'b0;
        end else if (clk_en) begin
            strap_pending <= 1'b0;
            if (strap_pending) begin
                unit_enable <= strap_s2;
            end else if (lo_lane && w_data[BIT_RESET]) begin
                unit_enable <= 1'b0;
                disable_pending <= 1'b0;
            end else if (lo_lane && w_data[BIT_ENABLE]) begin
                unit_enable <= 1'b1;
                disable_pending <= 1'b0;
            end else if (lo_lane && w_data[BIT_DISABLE]) begin
                disable_pending <= 1'b1;
            end else if (disable_pending && !frame_busy) begin
                unit_enable <= 1'b0;
                disable_pending <= 1'b0;
            end
        end
    end

    // first enabled edge after release loads the synced strap
    property p_strap;
        @(posedge aclk) disable iff (!aresetn)
        clk_en && strap_pending |=> unit_enable == $past(strap_s2);
    endproperty
    a_strap: assert property (p_strap)
        else $error("enable did not follow the strap");

    // new frames only while enabled and no disable is waiting
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            frame_start_allow <= 1'b0;
        end else if (clk_en) begin
            frame_start_allow <= unit_enable && !disable_pending
                && !(lo_lane && (w_data[BIT_DISABLE] || w_data[BIT_RESET]));
        end
    end

    // a waiting disable keeps new frames out
    property p_allow;
        @(posedge aclk) disable iff (!aresetn)
        clk_en && disable_pending |=> !frame_start_allow;
    endproperty
    a_allow: assert property (p_allow)
        else $error("frame start allowed during disable");

    // capture sets: manual capture writes any of the sixteen
    always_ff @(posedge aclk) begin
        if (clk_en && cmd.man_capture) begin
            if (cap_sel[3]) begin
                fall_cap[cap_sel[2:0]] <= clock_now;
            end else begin
                rise_cap[cap_sel[2:0]] <= clock_now;
            end
        end
    end

    // capture flags: set wins over clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rise_cap_flag <= 8'h00;
            fall_cap_flag <= 8'h00;
        end else if (clk_en) begin
            for (int i = 0; i < NUM_GPIO; i++) begin
                if (cmd.man_capture && !cap_sel[3]
                    && cap_sel[2:0] == 3'(i)) begin
                    rise_cap_flag[i] <= 1'b1;
                end else if (rise_clr[i] || cmd.unit_reset) begin
                    rise_cap_flag[i] <= 1'b0;
                end
                if (cmd.man_capture && cap_sel[3]
                    && cap_sel[2:0] == 3'(i)) begin
                    fall_cap_flag[i] <= 1'b1;
                end else if (fall_clr[i] || cmd.unit_reset) begin
                    fall_cap_flag[i] <= 1'b0;
                end
            end
        end
    end

    // falling-edge sets get their flag just like rising ones
    property p_fall_flag;
        @(posedge aclk) disable iff (!aresetn)
        clk_en && cmd.man_capture && cap_sel[3]
        |=> fall_cap_flag[$past(cap_sel[2:0])];
    endproperty
    a_fall_flag: assert property (p_fall_flag)
        else $error("falling capture flag not set");

    // flag clear: write one to clear at the frame control word
    always_comb begin
        rise_clr = 8'h00;
        fall_clr = 8'h00;
        if (wr_fire && aw_addr == ADDR_FRAME_CTL) begin
            rise_clr = w_strb[0] ? w_data[7:0] : 8'h00;
            fall_clr = w_strb[1] ? w_data[15:8] : 8'h00;
        end
    end

    // read channel: one cycle from address to data
    logic [31:0] rd_word;
    logic rd_ok;
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b1;
        unique case (s_axi_araddr)
            ADDR_CMD_CTL: begin
                // commands read zero, reserved bits zero
                rd_word[SEL_MSB:SEL_LSB] = cap_sel;
                rd_word[BIT_ENABLE] = unit_enable;
            end
            ADDR_CAP_SEL: rd_word[3:0] = cap_sel;
            ADDR_GPIO_CAP_CONFIG: rd_word = 32'h0000_0000;
            ADDR_RISE_SEC: rd_word = rise_cap[cap_sel[2:0]].sec;
            ADDR_RISE_NS: rd_word = rise_cap[cap_sel[2:0]].ns;
            ADDR_FALL_SEC: rd_word = fall_cap[cap_sel[2:0]].sec;
            ADDR_FALL_NS: rd_word = fall_cap[cap_sel[2:0]].ns;
            ADDR_FRAME_CTL: rd_word = {16'h0000, fall_cap_flag,
                rise_cap_flag};
            default: rd_ok = 1'b0;
        endcase
    end

    // read data registered; arready held off while data is pending
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (clk_en) begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid
                && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // checks
    property p_snap_pulse;
        @(posedge aclk) disable iff (!aresetn)
        clk_en && lo_lane && w_data[BIT_READ] |=> cmd.snap ##1 !cmd.snap;
    endproperty
    a_snap_pulse: assert property (p_snap_pulse)
        else $error("snapshot pulse wrong");
    property p_target;
        @(posedge aclk) disable iff (!aresetn)
        clk_en && hi_lane && w_data[BIT_TARGET_READ] |=> cmd.target_snap;
    endproperty
    a_target: assert property (p_target)
        else $error("target snapshot missing");
    property p_no_zero;
        @(posedge aclk) disable iff (!aresetn)
        clk_en && !(lo_lane && w_data[BIT_LOAD]) |=> !cmd.load;
    endproperty
    a_no_zero: assert property (p_no_zero)
        else $error("load without written one");
    property p_step;
        @(posedge aclk) disable iff (!aresetn)
        clk_en && lo_lane && w_data[BIT_STEP_SEC] && w_data[BIT_STEP_NS]
        |=> cmd.step_sec && cmd.step_ns;
    endproperty
    a_step: assert property (p_step)
        else $error("step pulses missing");
    property p_reset_dis;
        @(posedge aclk) disable iff (!aresetn)
        clk_en && !strap_pending && lo_lane && w_data[BIT_RESET]
        |=> !unit_enable && !frame_start_allow;
    endproperty
    a_reset_dis: assert property (p_reset_dis)
        else $error("unit reset did not disable");
    property p_disable_wait;
        @(posedge aclk) disable iff (!aresetn)
        clk_en && disable_pending && frame_busy && unit_enable
        && !cmd_wr |=> unit_enable;
    endproperty
    a_disable_wait: assert property (p_disable_wait)
        else $error("enable cleared while frame busy");
    property p_flag;
        @(posedge aclk) disable iff (!aresetn)
        clk_en && cmd.man_capture && !cap_sel[3]
        |=> rise_cap_flag[$past(cap_sel[2:0])];
    endproperty
    a_flag: assert property (p_flag)
        else $error("capture flag not set");
    property p_enable_on;
        @(posedge aclk) disable iff (!aresetn)
        clk_en && !strap_pending && lo_lane && w_data[BIT_ENABLE]
        && !w_data[BIT_RESET] |=> unit_enable;
    endproperty
    a_enable_on: assert property (p_enable_on)
        else $error("enable not set");
endmodule
`default_nettype wire

//--- src/ptpcc_pkg.sv
// package: register map, command bit positions and bus types for ptpcc
`default_nettype none
package ptpcc_pkg;
    localparam logic [11:0] ADDR_CMD_CTL = 12'h100;
    localparam logic [11:0] ADDR_GPIO_CAP_CONFIG = 12'h15c;
    localparam logic [11:0] ADDR_RISE_SEC = 12'h16c;
    localparam logic [11:0] ADDR_RISE_NS = 12'h170;
    localparam logic [11:0] ADDR_FALL_SEC = 12'h178;
    localparam logic [11:0] ADDR_FALL_NS = 12'h17c;
    localparam logic [11:0] ADDR_CAP_SEL = 12'h180;
    localparam logic [11:0] ADDR_FRAME_CTL = 12'h184;
    localparam int BIT_TARGET_READ = 13;
    localparam int SEL_LSB = 9;
    localparam int SEL_MSB = 12;
    localparam int BIT_MAN_CAP = 8;
    localparam int BIT_TEMP_RATE = 7;
    localparam int BIT_STEP_NS = 6;
    localparam int BIT_STEP_SEC = 5;
    localparam int BIT_LOAD = 4;
    localparam int BIT_READ = 3;
    localparam int BIT_ENABLE = 2;
    localparam int BIT_DISABLE = 1;
    localparam int BIT_RESET = 0;
    localparam logic [3:0] SEL_RESET = 4'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int NUM_GPIO = 8;
    // one-cycle command pulses toward the clock datapath
    typedef struct packed {
        logic target_snap;
        logic man_capture;
        logic temp_rate;
        logic step_ns;
        logic step_sec;
        logic load;
        logic snap;
        logic unit_reset;
    } ptpcc_cmd_s;
    // captured clock value
    typedef struct packed {
        logic [31:0] sec;
        logic [31:0] ns;
    } ptpcc_time_s;
endpackage
`default_nettype wire

//--- verif/tb_top.sv
// tb_top: self-checking bench for the timing command and control bank
`default_nettype none
module tb_top
    import ptpcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic clk_en = 1'b1;
    logic enable_strap = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [11:0] s_axi_araddr = 12'h0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    ptpcc_time_s clock_now = '0;
    logic frame_busy = 1'b0;
    ptpcc_cmd_s cmd;
    logic unit_enable;
    logic frame_start_allow;
    logic [7:0] rise_cap_flag;
    logic [7:0] fall_cap_flag;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;
    int hits = 0;
    logic [7:0] seen = 8'h0;
    logic [31:0] rs = 32'h614f4b04;
    logic [31:0] rd_data;
    logic [1:0] rsp;
    ptpcc_time_s cap;
    int bits [8] = '{BIT_TARGET_READ, BIT_MAN_CAP, BIT_TEMP_RATE,
        BIT_STEP_NS, BIT_STEP_SEC, BIT_LOAD, BIT_READ, BIT_RESET};

    ptpcc_top ptpcc_top_i (.aclk, .aresetn, .clk_en, .enable_strap,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .clock_now, .frame_busy, .cmd, .unit_enable,
        .frame_start_allow, .rise_cap_flag, .fall_cap_flag);

    // 25 mhz clock
    always #20 aclk = ~aclk;

    // collect command pulses; a pulse lasting two cycles shows as two hits
    always @(posedge aclk) begin
        cycles++;
        if (cmd !== 8'h00) begin
            seen |= cmd;
            hits++;
        end
        if (cycles == 5000) begin
            n_errors++;
            wrap_up();
        end
    end

    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction

    // control word as read back: select field and enable, all else zero
    function automatic logic [31:0] exp_ctl(logic [3:0] s, logic en);
        return {18'h0, 1'b0, s, 6'h0, en, 2'h0};
    endfunction

    task automatic cmp(input logic [31:0] got, exp, input string m);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %0t %s", $time, m);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                rsp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                rd_data = s_axi_rdata;
                rsp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask

    // reset long enough for the strap synchroniser to fill
    task automatic do_reset(input logic s);
        aresetn <= 1'b0;
        enable_strap <= s;
        repeat (16) @(posedge aclk);
        cmp(unit_enable, 0, "enable during reset");
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        cmp(unit_enable, s, "enable after reset");
    endtask

    task automatic wrap_up();
        if (n_errors == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // main sequence
    initial begin
        do_reset(1'b0);
        rd(ADDR_CMD_CTL);
        cmp(rd_data, exp_ctl(4'h0, 1'b0), "control reset value");
        // each command bit alone gives exactly one pulse of its own
        for (int i = 0; i < 8; i++) begin
            seen = 8'h0;
            hits = 0;
            wr(ADDR_CMD_CTL, 32'h1 << bits[i]);
            cmp(rsp, RESP_OKAY, "command write response");
            repeat (3) @(posedge aclk);
            cmp(seen, 8'h80 >> i, "wrong command pulse");
            cmp(hits, 1, "pulse not single");
            // the unit reads back off after every command bit, the reset bit included
            rd(ADDR_CMD_CTL);
            cmp(rd_data, exp_ctl(4'h0, 1'b0), "command bit reads");
        end
        // zeros and reserved bits only: nothing may happen
        seen = 8'h0;
        wr(ADDR_CMD_CTL, 32'hffffc000);
        repeat (3) @(posedge aclk);
        cmp(seen, 0, "pulse on zero write");
        rd(ADDR_CMD_CTL);
        cmp(rd_data, exp_ctl(4'h0, 1'b0), "reserved bits read");
        // only lane 1 present: the bit 3 request in lane 0 is dropped
        s_axi_wstrb <= 4'h2;
        seen = 8'h0;
        wr(ADDR_CMD_CTL, (32'h1 << BIT_TARGET_READ) | (32'h1 << BIT_READ));
        s_axi_wstrb <= 4'hf;
        repeat (3) @(posedge aclk);
        cmp(seen, 8'h80, "byte lane gating");
        // enable, then a graceful disable held off by a busy frame;
        // timestamp enable is never written while the unit is on
        wr(ADDR_CMD_CTL, 32'h1 << BIT_ENABLE);
        repeat (2) @(posedge aclk);
        cmp(unit_enable, 1, "enable bit");
        cmp(frame_start_allow, 1, "frames allowed");
        rd(ADDR_CMD_CTL);
        cmp(rd_data, exp_ctl(4'h0, 1'b1), "enable read");
        frame_busy <= 1'b1;
        wr(ADDR_CMD_CTL, 32'h1 << BIT_DISABLE);
        repeat (4) @(posedge aclk);
        cmp(unit_enable, 1, "enable dropped early");
        cmp(frame_start_allow, 0, "new frame allowed");
        // frame ends while the clock enable is low: nothing may move
        frame_busy <= 1'b0;
        clk_en <= 1'b0;
        repeat (4) @(posedge aclk);
        cmp(unit_enable, 1, "enable moved while frozen");
        clk_en <= 1'b1;
        repeat (4) @(posedge aclk);
        cmp(unit_enable, 0, "enable kept");
        // manual capture into all sixteen sets with random clock values
        for (int s = 0; s < 16; s++) begin
            cap = {rnd(), rnd()};
            clock_now <= cap;
            wr(ADDR_FRAME_CTL, 32'h0000ffff);
            wr(ADDR_CMD_CTL, (32'(s) << SEL_LSB) | (32'h1 << BIT_MAN_CAP));
            repeat (2) @(posedge aclk);
            cmp({fall_cap_flag, rise_cap_flag}, 32'h1 << s, "flag");
            rd(ADDR_CAP_SEL);
            cmp(rd_data, s, "capture select");
            rd(s[3] ? ADDR_FALL_SEC : ADDR_RISE_SEC);
            cmp(rd_data, cap.sec, "captured seconds");
            rd(s[3] ? ADDR_FALL_NS : ADDR_RISE_NS);
            cmp(rd_data, cap.ns, "captured nanoseconds");
        end
        // select written through its own word shows in the control word
        wr(ADDR_CAP_SEL, 32'h0000_0005);
        cmp(rsp, RESP_OKAY, "select write response");
        rd(ADDR_CMD_CTL);
        cmp(rd_data, exp_ctl(4'h5, 1'b0), "select mirror write");
        // unit reset after enable: disables and clears flags; the enable write has already loaded select 0
        wr(ADDR_CMD_CTL, 32'h1 << BIT_ENABLE);
        wr(ADDR_CMD_CTL, 32'h1 << BIT_RESET);
        repeat (2) @(posedge aclk);
        cmp(unit_enable, 0, "unit reset enable");
        cmp({fall_cap_flag, rise_cap_flag}, 0, "flags kept");
        rd(ADDR_CMD_CTL);
        cmp(rd_data, exp_ctl(4'h0, 1'b0), "unit reset read");
        // refused places
        wr(12'h108, rnd());
        cmp(rsp, RESP_SLVERR, "unmapped write");
        wr(ADDR_RISE_SEC, rnd());
        cmp(rsp, RESP_SLVERR, "capture write");
        rd(12'h108);
        cmp(rsp, RESP_SLVERR, "unmapped read");
        // second reset with the strap high
        do_reset(1'b1);
        rd(ADDR_CMD_CTL);
        cmp(rd_data, exp_ctl(4'h0, 1'b1), "strap enable read");
        wrap_up();
    end
endmodule
`default_nettype wire
